// ### design/bcs_regs_defs.svh
// Offsets, field positions, reset values and frame layout of the brake/status register block
`ifndef BCS_REGS_DEFS_SVH
`define BCS_REGS_DEFS_SVH

`define BCS_FRAME_BITS 6'h20
`define BCS_MODE_BIT 7
`define BCS_DATA_LSB 8
`define BCS_DATA_MSB 23
`define BCS_CRC_LSB 24

`define BCS_ADDR_BRAKE 7'h1d
`define BCS_ADDR_SUPPLY 7'h40
`define BCS_ADDR_THERMAL 7'h41
`define BCS_ADDR_DEVINFO 7'h42
`define BCS_ADDR_WAKESRC 7'h44
`define BCS_ADDR_WAKELVL 7'h45
`define BCS_ADDR_BRGEN 7'h50
`define BCS_ADDR_DLYREG 7'h51
`define BCS_ADDR_DRAIN_SOURCE_OV_STATUS 7'h52
`define BCS_ADDR_EFFDLY1 7'h53
`define BCS_ADDR_EFFDLY2 7'h54
`define BCS_ADDR_EFFDLY3 7'h55
`define BCS_ADDR_EDGE1 7'h57
`define BCS_ADDR_EDGE2 7'h58
`define BCS_ADDR_EDGE3 7'h59
`define BCS_ADDR_FAMID 7'h70

`define BCS_IDX_FAMID 4'hf

`define BCS_BRAKE_RST 16'h00a0
`define BCS_BRAKE_WMASK 16'h1fff
`define BCS_BRAKE_RESTART_KEEP 16'h1fe7

`define BCS_OVB_BASE_VOLTS 6'h1b

`define BCS_CRC_POLY 8'h1d
`define BCS_CRC_INIT 8'hff

`define BCS_RSP_ERR_BIT 0

`endif

// ### design/bcs_regs_pkg.sv
// Types and frame CRC shared by the brake/status register block
package bcs_regs_pkg;
`include "bcs_regs_defs.svh"

    typedef struct packed {
        logic [7:0] crc;
        logic [15:0] data;
        logic mode;
        logic [6:0] addr;
    } bcs_frame_t;

    typedef struct packed {
        logic [2:0] reserved_hi;
        logic hard_brake_low3_mask;
        logic hard_brake_low2_mask;
        logic hard_brake_low1_mask;
        logic hard_brake_en;
        logic brake_ds_threshold_sel;
        logic brake_blank_time_sel;
        logic parking_brake_enable;
        logic overvoltage_brake_enable;
        logic [1:0] reserved_field;
        logic [2:0] overvoltage_brake_level;
    } bcs_brake_t;

    typedef enum logic {
        BCS_IDLE,
        BCS_SHIFT
    } bcs_state_t;

    // Serial CRC over address, mode and data, bit 0 first as on the wire
    function automatic logic [7:0] bcs_crc8(input logic [23:0] d);
        logic [7:0] c;
        logic fb;
        c = `BCS_CRC_INIT;
        for (int i = 0; i < 24; i++) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ `BCS_CRC_POLY;
            end
        end
        return c;
    endfunction

endpackage

// ### design/bcs_regs.sv
// Serial register block: brake configuration word and read/clear status words
`timescale 1ns/100ps

module bcs_regs #(
    parameter int STAT_NUM = 16,
    parameter int STAT_W = 16,
    parameter logic [15:0][15:0] STAT_RC_MASK = {16'h0000, {15{16'hffff}}},
    // Identification value is arbitrary
    parameter logic [15:0] FAMILY_PRODUCT_ID = 16'h0001
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic soft_rst_in,
    input wire logic restart_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdi_in,
    output logic sdo_out,
    input wire logic [15:0][15:0] stat_set_in,
    input wire logic [15:0][15:0] stat_level_in,
    output bcs_regs_pkg::bcs_brake_t brake_cfg_out,
    output logic [5:0] ovb_level_volts_out,
    output logic frame_err_out
);
    import bcs_regs_pkg::*;

    if (STAT_NUM != 16 || STAT_W != 16) begin : g_size_check
        $error("bcs_regs serves exactly sixteen 16-bit status words");
    end

    bcs_state_t state_ff;
    bcs_state_t nxt_state;
    logic cs_q_ff;
    logic sclk_q_ff;
    logic [31:0] rx_ff;
    logic [31:0] tx_ff;
    logic [5:0] bit_cnt_ff;
    logic [15:0] brake_ff;
    logic [15:0] stat_ff [16];
    logic frame_err_ff;

    // status address map; index order matches the word storage
    function automatic logic [4:0] stat_lookup(input logic [6:0] a);
        logic [4:0] r;
        r = 5'h10;
        if (a == `BCS_ADDR_SUPPLY) begin
            r = 5'h00;
        end else if (a == `BCS_ADDR_THERMAL) begin
            r = 5'h01;
        end else if (a == `BCS_ADDR_DEVINFO) begin
            r = 5'h02;
        end else if (a == `BCS_ADDR_WAKESRC) begin
            r = 5'h03;
        end else if (a == `BCS_ADDR_WAKELVL) begin
            r = 5'h04;
        end else if (a == `BCS_ADDR_BRGEN) begin
            r = 5'h05;
        end else if (a == `BCS_ADDR_DLYREG) begin
            r = 5'h06;
        end else if (a == `BCS_ADDR_DRAIN_SOURCE_OV_STATUS) begin
            r = 5'h07;
        end else if (a == `BCS_ADDR_EFFDLY1) begin
            r = 5'h08;
        end else if (a == `BCS_ADDR_EFFDLY2) begin
            r = 5'h09;
        end else if (a == `BCS_ADDR_EFFDLY3) begin
            r = 5'h0a;
        end else if (a == `BCS_ADDR_EDGE1) begin
            r = 5'h0b;
        end else if (a == `BCS_ADDR_EDGE2) begin
            r = 5'h0c;
        end else if (a == `BCS_ADDR_EDGE3) begin
            r = 5'h0d;
        end else if (a == `BCS_ADDR_FAMID) begin
            r = 5'h0e + 5'h01;
        end
        return r;
    endfunction

    // Frame edges; pins are synchronous to mclk_in so one flop of history suffices
    wire sclk_rise = sclk_in & ~sclk_q_ff & ~cs_n_in;
    wire sclk_fall = ~sclk_in & sclk_q_ff & ~cs_n_in;
    wire frame_start = ~cs_n_in & cs_q_ff;
    wire frame_end = cs_n_in & ~cs_q_ff;

    // Frame fields
    bcs_frame_t frame;
    assign frame = bcs_frame_t'(rx_ff);
    wire len_ok = (bit_cnt_ff == `BCS_FRAME_BITS);
    wire crc_ok = (bcs_crc8(rx_ff[`BCS_DATA_MSB:0]) == frame.crc);
    wire frame_ok = frame_end & len_ok & crc_ok;
    wire [4:0] stat_hit = stat_lookup(frame.addr);
    wire is_stat = ~stat_hit[4];
    wire [3:0] stat_idx = stat_hit[3:0];
    wire is_brake = (frame.addr == `BCS_ADDR_BRAKE);
    wire brake_wr = frame_ok & frame.mode & is_brake;
    wire stat_clr = frame_ok & frame.mode & is_stat;

    // Read values; read-only bits follow the live level except in the identification word, clearable bits are sticky
    logic [15:0] stat_view [16];
    for (genvar g = 0; g < 16; g++) begin : g_view
        assign stat_view[g] = (g == `BCS_IDX_FAMID) ? FAMILY_PRODUCT_ID :
            ((stat_ff[g] & STAT_RC_MASK[g]) | (stat_level_in[g] & ~STAT_RC_MASK[g]));
    end

    // data in frame bits 8 to 23
    wire [15:0] rd_data = is_brake ? (brake_ff & `BCS_BRAKE_WMASK) :
        (is_stat ? stat_view[stat_idx] : 16'h0000);
    wire [7:0] rsp_lo = {7'h00, ~(len_ok & crc_ok)};
    wire [23:0] rsp_body = {rd_data, rsp_lo};
    wire [31:0] rsp_word = {bcs_crc8(rsp_body), rsp_body};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            BCS_IDLE: begin
                if (frame_start) begin
                    nxt_state = BCS_SHIFT;
                end
            end
            BCS_SHIFT: begin
                if (frame_end) begin
                    nxt_state = BCS_IDLE;
                end
            end
            default: nxt_state = BCS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_ff <= BCS_IDLE;
            cs_q_ff <= 1'b1;
            sclk_q_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cs_q_ff <= cs_n_in;
            sclk_q_ff <= sclk_in;
        end
    end

    // Receive, bit 0 first; count saturates so over-long frames are refused
    always_ff @(posedge mclk_in) begin
        if (srst_in || frame_start) begin
            rx_ff <= 32'h0000_0000;
            bit_cnt_ff <= 6'h00;
        end else if (sclk_rise && state_ff == BCS_SHIFT) begin
            rx_ff <= {sdi_in, rx_ff[31:1]};
            bit_cnt_ff <= (bit_cnt_ff == 6'h3f) ? bit_cnt_ff : bit_cnt_ff + 6'h01;
        end
    end

    // Answer goes out during the next frame, shifted on falling sclk
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            tx_ff <= 32'h0000_0000;
            frame_err_ff <= 1'b0;
        end else if (frame_end) begin
            tx_ff <= rsp_word;
            frame_err_ff <= ~(len_ok & crc_ok);
        end else if (sclk_fall) begin
            tx_ff <= {1'b0, tx_ff[31:1]};
        end
    end

    wire [15:0] brake_restart = brake_ff & `BCS_BRAKE_RESTART_KEEP;
    // Bits 4:3 are stored as written; the master is expected to keep them zero
    // reserved bits 15:13 never stored
    wire [15:0] brake_wdata = frame.data & `BCS_BRAKE_WMASK;

    always_ff @(posedge mclk_in) begin
        if (srst_in || soft_rst_in) begin
            brake_ff <= `BCS_BRAKE_RST;
        end else if (restart_in) begin
            brake_ff <= brake_restart;
        end else if (brake_wr) begin
            brake_ff <= brake_wdata;
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    for (genvar g = 0; g < 16; g++) begin : g_stat
        wire clr_this = stat_clr && (stat_idx == g);
        wire [15:0] nxt_stat = ((clr_this ? 16'h0000 : stat_ff[g]) | stat_set_in[g])
            & STAT_RC_MASK[g];
        always_ff @(posedge mclk_in) begin
            if (srst_in || soft_rst_in) begin
                stat_ff[g] <= 16'h0000;
            end else begin
                stat_ff[g] <= nxt_stat;
            end
        end
    end

    assign brake_cfg_out = bcs_brake_t'(brake_ff);
    assign ovb_level_volts_out = `BCS_OVB_BASE_VOLTS + {3'h0, brake_ff[2:0]};
    assign sdo_out = tx_ff[0];
    assign frame_err_out = frame_err_ff;

    a_reserved_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
        brake_ff[15:13] == 3'h0)
        else $error("Reserved brake bits not zero");

    a_reset_value: assert property (@(posedge mclk_in)
        srst_in |=> brake_cfg_out.overvoltage_brake_enable && !brake_cfg_out.hard_brake_en
        && !brake_cfg_out.parking_brake_enable && brake_cfg_out.brake_blank_time_sel
        && !brake_cfg_out.brake_ds_threshold_sel && brake_ff == 16'h00a0)
        else $error("Brake reset value wrong");

    a_restart_keep: assert property (@(posedge mclk_in) disable iff (srst_in)
        restart_in && !soft_rst_in |=> brake_ff == ($past(brake_ff) & 16'h1fe7))
        else $error("Restart did not keep brake bits");

    a_write_lands: assert property (@(posedge mclk_in) disable iff (srst_in)
        brake_wr && !soft_rst_in && !restart_in
        |=> brake_cfg_out.hard_brake_en == $past(rx_ff[17])
        && brake_cfg_out.hard_brake_low3_mask == $past(rx_ff[20]))
        else $error("Brake write not applied");

    a_mask_bits: assert property (@(posedge mclk_in) disable iff (srst_in)
        brake_wr && !soft_rst_in && !restart_in
        |=> brake_cfg_out.hard_brake_low1_mask == $past(rx_ff[18])
        && brake_cfg_out.hard_brake_low2_mask == $past(rx_ff[19]))
        else $error("Low-side mask bits not applied");

    a_level_volts: assert property (@(posedge mclk_in) disable iff (srst_in)
        ovb_level_volts_out == 6'h1b + {3'h0, brake_cfg_out.overvoltage_brake_level})
        else $error("Overvoltage level mapping wrong");

    a_bad_frame: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && !(len_ok && crc_ok) && !soft_rst_in && !restart_in
        |=> $stable(brake_ff) && frame_err_out)
        else $error("Bad frame changed the brake word");

    a_clear_word: assert property (@(posedge mclk_in) disable iff (srst_in)
        stat_clr && stat_set_in[stat_idx] == 16'h0000 && !soft_rst_in
        |=> stat_ff[$past(stat_idx)] == 16'h0000)
        else $error("Clear did not empty the status word");

    a_read_keeps: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_ok && !frame.mode && is_stat && !soft_rst_in
        |=> (stat_ff[$past(stat_idx)] & $past(stat_ff[stat_idx]))
        == $past(stat_ff[stat_idx]))
        else $error("Read changed a status word");

    a_sticky_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
        !stat_clr && !soft_rst_in |=> (stat_ff[0] & $past(stat_ff[0])) == $past(stat_ff[0]))
        else $error("Status bit dropped without clear");

    a_answer_data: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && frame.addr == 7'h70 |=> tx_ff[23:8] == FAMILY_PRODUCT_ID)
        else $error("Identification word not answered");

    a_soft_reset: assert property (@(posedge mclk_in) disable iff (srst_in)
        soft_rst_in
        |=> brake_ff == 16'h00a0 && stat_ff[0] == 16'h0000)
        else $error("Soft reset left brake or status values");

    a_restart_status: assert property (@(posedge mclk_in) disable iff (srst_in)
        restart_in && !soft_rst_in && !stat_clr && stat_set_in[0] == 16'h0000
        |=> stat_ff[0] == $past(stat_ff[0]))
        else $error("Restart changed a status word");

    a_set_wins: assert property (@(posedge mclk_in) disable iff (srst_in)
        stat_set_in[0] != 16'h0000 && !soft_rst_in
        |=> (stat_ff[0] & $past(stat_set_in[0]) & STAT_RC_MASK[0])
        == ($past(stat_set_in[0]) & STAT_RC_MASK[0]))
        else $error("Status event not captured");

    a_write_level: assert property (@(posedge mclk_in) disable iff (srst_in)
        brake_wr && !soft_rst_in && !restart_in
        |=> brake_cfg_out.overvoltage_brake_level == $past(rx_ff[10:8]))
        else $error("Overvoltage level not written");

    a_write_enables: assert property (@(posedge mclk_in) disable iff (srst_in)
        brake_wr && !soft_rst_in && !restart_in
        |=> brake_cfg_out.parking_brake_enable == $past(rx_ff[14])
        && brake_cfg_out.overvoltage_brake_enable == $past(rx_ff[13]))
        else $error("Brake enables not written");

    a_write_selects: assert property (@(posedge mclk_in) disable iff (srst_in)
        brake_wr && !soft_rst_in && !restart_in
        |=> brake_cfg_out.brake_ds_threshold_sel == $past(rx_ff[16])
        && brake_cfg_out.brake_blank_time_sel == $past(rx_ff[15]))
        else $error("Threshold or blank select not written");

    a_rsp_crc: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end
        |=> tx_ff[31:24] == bcs_crc8(tx_ff[23:0]))
        else $error("Answer check byte wrong");

    a_rsp_brake: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && frame.addr == 7'h1d
        |=> tx_ff[23:8] == $past(brake_ff))
        else $error("Brake word not answered");

    a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && (frame.addr == 7'h43 || frame.addr == 7'h56 || frame.addr == 7'h5a)
        |=> tx_ff[23:8] == 16'h0000)
        else $error("Unmapped address answered data");

    a_status_first: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && frame.addr == 7'h40
        |=> tx_ff[23:8] == (($past(stat_ff[0]) & STAT_RC_MASK[0])
        | ($past(stat_level_in[0]) & ~STAT_RC_MASK[0])))
        else $error("First status word not answered");

    a_status_last: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && frame.addr == 7'h59
        |=> tx_ff[23:8] == (($past(stat_ff[13]) & STAT_RC_MASK[13])
        | ($past(stat_level_in[13]) & ~STAT_RC_MASK[13])))
        else $error("Last bridge status word not answered");

    a_frame_good: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_end && len_ok && crc_ok
        |=> !frame_err_out)
        else $error("Good frame flagged as faulty");

    a_shift_fall: assert property (@(posedge mclk_in) disable iff (srst_in)
        sclk_fall
        |=> tx_ff == {1'b0, $past(tx_ff[31:1])})
        else $error("Answer not shifted on falling clock");

    a_idle_hold: assert property (@(posedge mclk_in) disable iff (srst_in)
        state_ff == BCS_IDLE && !frame_start
        |=> $stable(rx_ff))
        else $error("Receive register moved outside a frame");

    a_start_clears: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_start
        |=> bit_cnt_ff == 6'h00 && rx_ff == 32'h0000_0000)
        else $error("Frame start did not clear the receiver");

    a_read_no_brake: assert property (@(posedge mclk_in) disable iff (srst_in)
        frame_ok && !frame.mode && !soft_rst_in && !restart_in
        |=> $stable(brake_ff))
        else $error("Read changed the brake word");

    a_clear_no_brake: assert property (@(posedge mclk_in) disable iff (srst_in)
        stat_clr && !soft_rst_in && !restart_in
        |=> $stable(brake_ff))
        else $error("Status clear changed the brake word");

endmodule // bcs_regs

// ### sim/bcs_master_model.sv
// Serial master model that frames commands and captures the answers
`timescale 1ns/100ps

module bcs_master_model (
    input wire logic mclk_in,
    input wire logic start_in,
    input wire logic slow_in,
    input wire logic [5:0] nbits_in,
    input wire logic [31:0] frame_in,
    input wire logic sdo_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic sdi_out,
    output logic done_out,
    output logic [31:0] rsp_out
);
    int ph;

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
        done_out = 1'b0;
        rsp_out = '0;
    end

    always begin
        @(posedge mclk_in);
        done_out <= 1'b0;
        if (start_in) begin
            ph = slow_in ? 7 : 3;
            cs_n_out <= 1'b0;
            for (int i = 0; i < int'(nbits_in); i++) begin
                sclk_out <= 1'b0;
                sdi_out <= frame_in[i];
                repeat (ph) @(posedge mclk_in);
                sclk_out <= 1'b1;
                repeat (ph) @(posedge mclk_in);
                rsp_out[i] <= sdo_in;
            end
            sclk_out <= 1'b0;
            // Released line shows the inverse so a stale bit cannot pass
            sdi_out <= ~sdi_out;
            repeat (ph) @(posedge mclk_in);
            cs_n_out <= 1'b1;
            repeat (3) @(posedge mclk_in);
            done_out <= 1'b1;
        end
    end
endmodule // bcs_master_model

// ### sim/bcs_regs_bench.sv
// Self-checking bench for the brake/status register block
`timescale 1ns/100ps

module bcs_regs_bench;
    import bcs_regs_pkg::*;
    logic mclk_in, srst_in, soft_rst_in, restart_in, start, slow;
    logic cs_n, sclk, sdi, sdo, done, frame_err, pend_v, pend_err;
    logic [5:0] nbits, volts;
    logic [31:0] frame, rsp;
    logic [15:0][15:0] stat_set, stat_level;
    logic [15:0] pend_data, cur, d;
    logic [6:0] addrs [16];
    bcs_brake_t brake;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    // Word 1 keeps only its low nibble clearable so read-only bits get exercised
    bcs_regs #(.STAT_RC_MASK({16'h0000, {13{16'hffff}}, 16'h000f, 16'hffff})) dut (
        .mclk_in(mclk_in), .srst_in(srst_in), .soft_rst_in(soft_rst_in),
        .restart_in(restart_in), .cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi),
        .sdo_out(sdo), .stat_set_in(stat_set), .stat_level_in(stat_level),
        .brake_cfg_out(brake), .ovb_level_volts_out(volts), .frame_err_out(frame_err));

    bcs_master_model mcu (.mclk_in(mclk_in), .start_in(start), .slow_in(slow),
        .nbits_in(nbits), .frame_in(frame), .sdo_in(sdo), .cs_n_out(cs_n),
        .sclk_out(sclk), .sdi_out(sdi), .done_out(done), .rsp_out(rsp));

    function automatic logic [7:0] crc8(input logic [23:0] b);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 0; i < 24; i++) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h1d : 8'h00);
        end
        return c;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bad: 0 good, 1 corrupt check byte, 2 one bit short; exp is the data answered next frame
    task automatic xfer(input logic [6:0] a, input logic m, input logic [15:0] dat,
                        input logic [15:0] exp, input int bad);
        logic [23:0] body;
        logic [7:0] crc_keep;
        body = {dat, m, a};
        crc_keep = (bad == 2) ? 8'h7f : 8'hff;
        @(posedge mclk_in);
        frame <= {crc8(body) ^ ((bad == 1) ? 8'h01 : 8'h00), body};
        nbits <= (bad == 2) ? 6'h1f : 6'h20;
        start <= 1'b1;
        @(posedge mclk_in);
        start <= 1'b0;
        for (int n = 0; n < 1000; n++) begin
            @(posedge mclk_in);
            if (done === 1'b1) break;
        end
        chk("xfer_done", 1'b1, done);
        if (pend_v) begin
            chk("rsp_err", {7'h00, pend_err}, rsp[7:0]);
            // A cut frame clocks out only 31 answer bits, so its top bit is stale
            chk("rsp_crc", crc8(rsp[23:0]) & crc_keep, rsp[31:24] & crc_keep);
            if (!pend_err) chk("rsp_data", pend_data, rsp[23:8]);
        end
        pend_v = 1'b1;
        pend_data = exp;
        pend_err = (bad != 0);
    endtask

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        {srst_in, soft_rst_in, restart_in, start, slow, pend_v, pend_err} = 7'h40;
        nbits = 6'h20;
        frame = '0;
        stat_set = '0;
        stat_level = '0;
        stat_level[1] = 16'h5a50;
        addrs = '{7'h40, 7'h41, 7'h42, 7'h44, 7'h45, 7'h50, 7'h51, 7'h52,
                  7'h53, 7'h54, 7'h55, 7'h57, 7'h58, 7'h59, 7'h70, 7'h43};
        repeat (20) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        cur = 16'h00a0;
        chk("brake_rst", cur, brake);
        chk("volts_rst", 27, volts);
        // Each control bit alone, with every level code
        for (int b = 0; b < 8; b++) begin
            d = (16'h0020 << b) | 16'(b);
            xfer(7'h1d, 1'b1, d, cur, 0);
            cur = d & 16'h1fe7;
            chk("brake_bit", cur, brake);
            chk("volts", 27 + (b % 8), volts);
        end
        xfer(7'h1d, 1'b1, 16'hffe7, cur, 0);
        cur = 16'h1fe7;
        chk("brake_rsv", cur, brake);
        xfer(7'h1d, 1'b1, 16'h1e1d, cur, 0);
        cur = 16'h1e1d;
        @(posedge mclk_in);
        restart_in <= 1'b1;
        @(posedge mclk_in);
        restart_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        cur = 16'h1e05;
        chk("brake_restart", cur, brake);
        xfer(7'h1d, 1'b1, 16'h0000, cur, 1);
        chk("brake_badcrc", cur, brake);
        chk("err_badcrc", 1'b1, frame_err);
        xfer(7'h1d, 1'b1, 16'h0000, cur, 2);
        chk("brake_short", cur, brake);
        xfer(7'h1d, 1'b0, 16'h5555, cur, 0);
        chk("err_good", 1'b0, frame_err);
        @(posedge mclk_in);
        soft_rst_in <= 1'b1;
        @(posedge mclk_in);
        soft_rst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        cur = 16'h00a0;
        chk("brake_soft", cur, brake);
        for (int k = 0; k < 15; k++) begin
            stat_set[k] <= 16'h0100 | 16'(k);
        end
        @(posedge mclk_in);
        stat_set <= '0;
        xfer(addrs[0], 1'b0, 16'hffff, 16'h0100, 0);
        for (int k = 0; k < 16; k++) begin
            d = (k == 14) ? 16'h0001 : ((k == 15) ? 16'h0000 : 16'h0100 | 16'(k));
            if (k == 1) d = 16'h5a51;
            xfer(addrs[k], 1'b0, 16'hffff, d, 0);
        end
        xfer(addrs[0], 1'b1, 16'h0000, 16'h0100, 0);
        xfer(addrs[14], 1'b1, 16'hffff, 16'h0001, 0);
        slow <= 1'b1;
        xfer(addrs[14], 1'b0, 16'h0000, 16'h0001, 0);
        xfer(addrs[0], 1'b0, 16'h0000, 16'h0000, 0);
        xfer(addrs[1], 1'b1, 16'h0000, 16'h5a51, 0);
        xfer(addrs[1], 1'b0, 16'h0000, 16'h5a50, 0);
        xfer(7'h1d, 1'b0, 16'h0000, cur, 0);
        xfer(addrs[15], 1'b0, 16'h0000, 16'h0000, 0);
        conclude();
    end
endmodule // bcs_regs_bench
